// File: design/pmc_pkg.sv
// Constants, register map and mode encodings of the power-mode controller
// Assumes a 100 MHz core clock and an AXI4-Lite master on the register side
// Summary of operation
// (R1) Idle gates CPU and memory clocks; enabled peripherals keep clocks.
// (R2) Any interrupt in idle returns the device to active.
// (R3) Wake latency 14 us idle, 174 us standby, 1015 us shutdown or pin hold.
// (R4) Standby powers only always-on domain; wake needs pin, RTC or sensor event.
// (R5) Standby wake resumes CPU in place; retained peripherals keep configuration.
// (R6) All GPIOs held at latched level throughout standby.
// (R7) Shutdown powers everything off; pins held at pre-shutdown values.
// (R8) Shutdown wake pin level change wakes device as a reset trigger.
// (R9) Reset cause recorded; pin wake, reset pin and power-on distinguishable.
// (R10) Shutdown keeps only latched pins and flash; registers and SRAM lost.
// (R11) RTC wake in active/idle/standby; pin wake except pin hold; reset pin always.
// (R12) Brown-out on in active/idle, duty cycled standby, off shutdown; POR always. Code turns the POR detector off in pin hold.
// (R13) Brown-out off between standby recharges; dip may lock until reset.
// (R14) SRAM is two 4 KB and two 6 KB blocks, retention per block.
// (R15) Flash cache disabled makes the 8 KB cache general-purpose RAM.
// (R16) 24 MHz crystal doubled to 48 MHz; fast clock off standby and shutdown.
// (R17) Slow RC serves without slow crystal; slow clock stops only in shutdown. Code also stops the slow clock in pin hold.
// (R18) Low-power entry only on software request, acknowledged after gating.
package pmc_pkg;
	localparam int CLK_MHZ = 100;
	localparam int WAKE_IDLE_US = 14;
	localparam int WAKE_STBY_US = 174;
	localparam int WAKE_SHDN_US = 1015;
	localparam int WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
	localparam int WAKE_STBY_CYC = WAKE_STBY_US * CLK_MHZ;
	localparam int WAKE_SHDN_CYC = WAKE_SHDN_US * CLK_MHZ;
	localparam int RECHG_PERIOD_CYC = 1000;
	localparam int RECHG_ON_CYC = 10;
	localparam int NGPIO = 8;
	// Synchroniser reset value: reset pin bit at its released (high) level
	localparam logic [22:0] SYNC_RST = 23'h00_0800;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_RETN = 8'h08;
	localparam logic [7:0] OFS_WPIN = 8'h0C;
	localparam logic [7:0] OFS_RCAUSE = 8'h10;
	localparam logic [7:0] OFS_IRQ = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [1:0] REQ_NONE = 2'h0;
	localparam logic [1:0] REQ_IDLE = 2'h1;
	localparam logic [1:0] REQ_STBY = 2'h2;
	localparam logic [1:0] REQ_SHDN = 2'h3;
	localparam logic [2:0] RC_POR = 3'h1;
	localparam logic [2:0] RC_PIN = 3'h2;
	localparam logic [2:0] RC_WAKE = 3'h4;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	typedef enum logic [6:0] {
		PMC_ACTIVE  = 7'h01,
		PMC_GATE    = 7'h02,
		PMC_IDLE    = 7'h04,
		PMC_STBY    = 7'h08,
		PMC_SHDN    = 7'h10,
		PMC_WAKE    = 7'h20,
		PMC_PINHOLD = 7'h40
	} pmc_state_t;
endpackage

// File: design/pmc_top.sv
// Power-mode controller: mode sequencing, domain gating, wake and reset cause
// Assumes AXI4-Lite master on CORE_CLK; wake and reset sources are asynchronous pins
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module pmc_top
	import pmc_pkg::*;
(
	input  wire logic              CORE_CLK,
	input  wire logic              ARST_N,
	input  wire logic              CLK_EN,
	input  wire logic [7:0]        S_AWADDR,
	input  wire logic              S_AWVALID,
	output logic                   S_AWREADY,
	input  wire logic [31:0]       S_WDATA,
	input  wire logic [3:0]        S_WSTRB,
	input  wire logic              S_WVALID,
	output logic                   S_WREADY,
	output logic [1:0]             S_BRESP,
	output logic                   S_BVALID,
	input  wire logic              S_BREADY,
	input  wire logic [7:0]        S_ARADDR,
	input  wire logic              S_ARVALID,
	output logic                   S_ARREADY,
	output logic [31:0]            S_RDATA,
	output logic [1:0]             S_RRESP,
	output logic                   S_RVALID,
	input  wire logic              S_RREADY,
	input  wire logic              IRQ_EVENT,
	input  wire logic              RTC_EVENT,
	input  wire logic              SENSOR_EVENT,
	input  wire logic [NGPIO-1:0]  WAKE_PIN,
	input  wire logic              RESET_PIN_N,
	input  wire logic              POR_EVENT,
	input  wire logic              BROWNOUT_TRIP,
	input  wire logic              SLOW_XTAL_PRESENT,
	input  wire logic [NGPIO-1:0]  GPIO_IN,
	output logic                   CPU_CLK_EN,
	output logic                   MEM_CLK_EN,
	output logic                   FLASH_PWR,
	output logic                   SRAM_PWR,
	output logic [3:0]             SRAM_RETAIN,
	output logic                   CACHE_AS_RAM,
	output logic                   RADIO_PWR,
	output logic                   PERIPH_PWR,
	output logic                   ALWAYS_ON_DOMAIN_PWR,
	output logic                   FAST_CRYSTAL_OSC_EN,
	output logic                   FAST_DOUBLER_EN,
	output logic                   SLOW_CRYSTAL_OSC_EN,
	output logic                   SLOW_RC_OSC_EN,
	output logic                   BROWNOUT_DETECTOR_EN,
	output logic                   POR_DETECT_EN,
	output logic                   GPIO_LATCH,
	output logic [NGPIO-1:0]       GPIO_HOLD_VAL,
	output logic                   SYS_RESET_N,
	output logic                   LP_ACK,
	output logic                   IRQ
);
	// ----------------------------------------------------------------
	// Reset and input synchronisers
	// ----------------------------------------------------------------
	logic              rst_s1, rst_n;
	logic [14+NGPIO:0] sy1, sy2;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end
	wire [14+NGPIO:0] sy_in = {8'h00, IRQ_EVENT, RTC_EVENT, SENSOR_EVENT, RESET_PIN_N,
		POR_EVENT, BROWNOUT_TRIP, SLOW_XTAL_PRESENT, WAKE_PIN};
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			sy1 <= SYNC_RST;
			sy2 <= SYNC_RST;
		end else if (CLK_EN) begin
			sy1 <= sy_in;
			sy2 <= sy1;
		end
	end
	wire [NGPIO-1:0] wpin   = sy2[NGPIO-1:0];
	wire             xtal_ok = sy2[NGPIO];
	wire             bod_trip = sy2[NGPIO+1];
	wire             por_ev = sy2[NGPIO+2];
	wire             rpin_n = sy2[NGPIO+3];
	wire             sen_ev = sy2[NGPIO+4];
	wire             rtc_ev = sy2[NGPIO+5];
	wire             irq_ev = sy2[NGPIO+6];
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [1:0]       req;
	logic [3:0]       retn;
	logic             cache_off;
	logic [NGPIO-1:0] wpin_en;
	logic [2:0]       rcause;
	logic [3:0]       irq_st, irq_mask;
	logic [7:0]       aw_a;
	logic [31:0]      w_d;
	logic             aw_h, w_h, bod_lock;
	pmc_state_t       state, next_state;
	logic [17:0]      cnt;
	logic [NGPIO-1:0] wpin_ref;
	wire do_wr = aw_h && w_h && !S_BVALID;
	wire wr_ctrl = do_wr && aw_a == OFS_CTRL;
	wire wr_retn = do_wr && aw_a == OFS_RETN;
	wire wr_wpin = do_wr && aw_a == OFS_WPIN;
	wire wr_rc   = do_wr && aw_a == OFS_RCAUSE;
	wire wr_irq  = do_wr && aw_a == OFS_IRQ;
	wire wr_mask = do_wr && aw_a == OFS_MASK;
	wire wr_ok   = wr_ctrl | wr_retn | wr_wpin | wr_rc | wr_irq | wr_mask | (do_wr && aw_a == OFS_STAT);
	wire rd_go   = S_ARVALID && !S_RVALID;
	wire [31:0] rd_mux = (S_ARADDR == OFS_CTRL)   ? {27'h0, cache_off, 2'h0, req} :
		(S_ARADDR == OFS_STAT)   ? {24'h0, bod_lock, state} :
		(S_ARADDR == OFS_RETN)   ? {28'h0, retn} :
		(S_ARADDR == OFS_WPIN)   ? {24'h0, wpin_en} :
		(S_ARADDR == OFS_RCAUSE) ? {29'h0, rcause} :
		(S_ARADDR == OFS_IRQ)    ? {28'h0, irq_st} :
		(S_ARADDR == OFS_MASK)   ? {28'h0, irq_mask} : RD_ZERO;
	wire rd_ok = S_ARADDR <= OFS_MASK && S_ARADDR[1:0] == 2'h0;
	wire pin_chg = |((wpin ^ wpin_ref) & wpin_en);
	wire rpin_hit = !rpin_n;
	wire lp_wake = rtc_ev | sen_ev | pin_chg;
	wire ev_entered = state == PMC_GATE && cnt == 18'h0;
	wire ev_woke = state == PMC_WAKE && cnt == 18'h0;
	wire [3:0] irq_set = {bod_trip & BROWNOUT_DETECTOR_EN, rpin_hit, ev_woke, ev_entered};
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_h <= 1'b0;
			w_h <= 1'b0;
			aw_a <= 8'h00;
			w_d <= 32'h0000_0000;
			S_BVALID <= 1'b0;
			S_BRESP <= RESP_OK;
			S_RVALID <= 1'b0;
			S_RDATA <= RD_ZERO;
			S_RRESP <= RESP_OK;
		end else if (CLK_EN) begin
			if (S_AWVALID && S_AWREADY) begin
				aw_h <= 1'b1;
				aw_a <= S_AWADDR;
			end
			if (S_WVALID && S_WREADY) begin
				w_h <= 1'b1;
				w_d <= S_WDATA;
			end
			if (do_wr) begin
				aw_h <= 1'b0;
				w_h <= 1'b0;
				S_BVALID <= 1'b1;
				S_BRESP <= wr_ok ? RESP_OK : RESP_SLVERR;
			end else if (S_BREADY) begin
				S_BVALID <= 1'b0;
			end
			if (rd_go) begin
				S_RVALID <= 1'b1;
				S_RDATA <= rd_mux;
				S_RRESP <= rd_ok ? RESP_OK : RESP_SLVERR;
			end else if (S_RREADY) begin
				S_RVALID <= 1'b0;
			end
		end
	end
	assign S_AWREADY = !aw_h && rst_n;
	assign S_WREADY  = !w_h && rst_n;
	assign S_ARREADY = rd_go && rst_n;
	// Byte lane 0 carries every field
	wire b0 = w_d[0] | !S_WSTRB[0] ? S_WSTRB[0] : 1'b0;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			req <= REQ_NONE;
			retn <= 4'hF;
			cache_off <= 1'b0;
			wpin_en <= '0;
			irq_mask <= 4'h0;
			irq_st <= 4'h0;
		end else if (CLK_EN) begin
			if (state == PMC_SHDN) begin
				req <= REQ_NONE; // see (R10)
				retn <= 4'hF;
				cache_off <= 1'b0;
				irq_mask <= 4'h0;
			end else begin
				if (wr_ctrl) begin
					req <= w_d[1:0]; // see (R18)
					cache_off <= w_d[4];
				end else if (state == PMC_WAKE)
					req <= REQ_NONE;
				if (wr_retn)
					retn <= w_d[3:0]; // see (R14)
				if (wr_mask)
					irq_mask <= w_d[3:0];
			end
			if (wr_wpin)
				wpin_en <= w_d[NGPIO-1:0];
			irq_st <= (irq_st & ~(wr_irq ? w_d[3:0] : 4'h0)) | irq_set;
		end
	end
	// ----------------------------------------------------------------
	// Mode sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			PMC_ACTIVE:  next_state = (req != REQ_NONE) ? PMC_GATE : PMC_ACTIVE; // see (R18)
			PMC_GATE:    if (cnt == 18'h0) begin
				next_state = (req == REQ_IDLE) ? PMC_IDLE : (req == REQ_STBY) ? PMC_STBY : PMC_SHDN;
			end
			PMC_IDLE:    next_state = (irq_ev | lp_wake) ? PMC_WAKE : PMC_IDLE; // see (R2)
			PMC_STBY:    next_state = (lp_wake && !bod_lock) ? PMC_WAKE : PMC_STBY; // see (R4) (R11) (R13)
			PMC_SHDN:    next_state = pin_chg ? PMC_WAKE : PMC_SHDN; // see (R8) (R11)
			PMC_WAKE:    next_state = (cnt == 18'h0) ? PMC_ACTIVE : PMC_WAKE; // see (R3)
			PMC_PINHOLD: next_state = rpin_hit ? PMC_PINHOLD : PMC_WAKE;
			default:     next_state = PMC_ACTIVE;
		endcase
		if (rpin_hit)
			next_state = PMC_PINHOLD; // see (R11)
	end
	wire [17:0] wake_len = (state == PMC_IDLE) ? 18'(WAKE_IDLE_CYC - 1) :
		(state == PMC_STBY) ? 18'(WAKE_STBY_CYC - 1) : 18'(WAKE_SHDN_CYC - 1); // see (R3)
	logic [9:0] rch;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= PMC_WAKE;
			cnt <= 18'(WAKE_SHDN_CYC - 1);
			wpin_ref <= '0;
			rch <= 10'h000;
			bod_lock <= 1'b0;
			rcause <= RC_POR;
			GPIO_HOLD_VAL <= '0;
		end else if (CLK_EN) begin
			state <= next_state;
			if (state != next_state)
				cnt <= (next_state == PMC_WAKE) ? wake_len : 18'h3;
			else if (cnt != 18'h0)
				cnt <= cnt - 18'h1;
			if (state == PMC_GATE && next_state != PMC_GATE)
				GPIO_HOLD_VAL <= GPIO_IN; // see (R6) (R7)
			if (state != PMC_SHDN)
				wpin_ref <= wpin;
			rch <= (rch == 10'(RECHG_PERIOD_CYC - 1)) ? 10'h000 : rch + 10'h001;
			if (state == PMC_STBY && bod_trip)
				bod_lock <= 1'b1; // see (R13)
			else if (rpin_hit)
				bod_lock <= 1'b0;
			if (por_ev)
				rcause <= RC_POR; // see (R9)
			else if (rpin_hit)
				rcause <= RC_PIN;
			else if (state == PMC_SHDN && pin_chg)
				rcause <= RC_WAKE;
			else if (wr_rc && b0)
				rcause <= 3'h0;
		end
	end
	// ----------------------------------------------------------------
	// Domain outputs
	// ----------------------------------------------------------------
	wire run = state == PMC_ACTIVE || state == PMC_GATE;
	wire on_idle = run || state == PMC_IDLE;
	wire low = state == PMC_STBY;
	wire off = state == PMC_SHDN || state == PMC_PINHOLD;
	wire waking = state == PMC_WAKE;
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			{CPU_CLK_EN, MEM_CLK_EN, FLASH_PWR, SRAM_PWR, RADIO_PWR, PERIPH_PWR} <= 6'h00;
			SRAM_RETAIN <= 4'h0;
			CACHE_AS_RAM <= 1'b0;
			ALWAYS_ON_DOMAIN_PWR <= 1'b0;
			{FAST_CRYSTAL_OSC_EN, FAST_DOUBLER_EN, SLOW_CRYSTAL_OSC_EN, SLOW_RC_OSC_EN} <= 4'h0;
			BROWNOUT_DETECTOR_EN <= 1'b0;
			POR_DETECT_EN <= 1'b1;
			GPIO_LATCH <= 1'b0;
			SYS_RESET_N <= 1'b0;
			LP_ACK <= 1'b0;
			IRQ <= 1'b0;
		end else if (CLK_EN) begin
			CPU_CLK_EN <= run; // see (R1)
			MEM_CLK_EN <= run;
			FLASH_PWR <= on_idle;
			SRAM_PWR <= on_idle | low | waking; // see (R5)
			SRAM_RETAIN <= low ? retn : 4'hF; // see (R14)
			CACHE_AS_RAM <= cache_off; // see (R15)
			RADIO_PWR <= on_idle;
			PERIPH_PWR <= on_idle; // see (R1) (R4)
			ALWAYS_ON_DOMAIN_PWR <= !off; // see (R4) (R7)
			FAST_CRYSTAL_OSC_EN <= on_idle || waking; // see (R16)
			FAST_DOUBLER_EN <= on_idle || waking;
			SLOW_CRYSTAL_OSC_EN <= !off && xtal_ok; // see (R17)
			SLOW_RC_OSC_EN <= !off && !xtal_ok;
			BROWNOUT_DETECTOR_EN <= on_idle || waking || (low && rch < 10'(RECHG_ON_CYC)); // see (R12)
			POR_DETECT_EN <= state != PMC_PINHOLD; // see (R12)
			GPIO_LATCH <= low || off; // see (R6) (R7)
			SYS_RESET_N <= !(off || (waking && rcause != 3'h0 && cnt > 18'(WAKE_STBY_CYC))); // see (R8) (R10)
			LP_ACK <= state == PMC_IDLE || low || state == PMC_SHDN; // see (R18)
			IRQ <= |(irq_st & irq_mask);
		end
	end
endmodule // pmc_top

// File: bench/pmc_top_asserts.sv
// Checker of the power-mode controller's mode and gating outputs
// Assumes it is bound into pmc_top and sees only its ports
`timescale 1ns/1ps
module pmc_top_asserts
	import pmc_pkg::*;
(
	input wire logic             CORE_CLK,
	input wire logic             ARST_N,
	input wire logic             SLOW_XTAL_PRESENT,
	input wire logic             RESET_PIN_N,
	input wire logic             LP_ACK,
	input wire logic             CPU_CLK_EN,
	input wire logic             MEM_CLK_EN,
	input wire logic             FLASH_PWR,
	input wire logic             SRAM_PWR,
	input wire logic             RADIO_PWR,
	input wire logic             PERIPH_PWR,
	input wire logic             ALWAYS_ON_DOMAIN_PWR,
	input wire logic             FAST_CRYSTAL_OSC_EN,
	input wire logic             FAST_DOUBLER_EN,
	input wire logic             SLOW_CRYSTAL_OSC_EN,
	input wire logic             SLOW_RC_OSC_EN,
	input wire logic             BROWNOUT_DETECTOR_EN,
	input wire logic             POR_DETECT_EN,
	input wire logic             GPIO_LATCH,
	input wire logic [NGPIO-1:0] GPIO_HOLD_VAL,
	input wire logic             SYS_RESET_N
);
	// ----
	// Wake timer and standby detector window
	// ----
	logic [16:0] lat;
	logic [1:0]  kind;
	logic [3:0]  bod_run;
	int          lim;
	logic        stby;
	assign stby = LP_ACK && ALWAYS_ON_DOMAIN_PWR && !PERIPH_PWR;
	assign lim = (kind == 2'h0) ? WAKE_IDLE_CYC : (kind == 2'h1) ? WAKE_STBY_CYC : WAKE_SHDN_CYC;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lat <= '0;
			kind <= 2'h2;
		end else if (LP_ACK || !RESET_PIN_N) begin
			lat <= '0;
			kind <= (!ALWAYS_ON_DOMAIN_PWR || !RESET_PIN_N) ? 2'h2 : (PERIPH_PWR ? 2'h0 : 2'h1);
		end else if (!CPU_CLK_EN) begin
			lat <= lat + 17'h1;
		end
	end
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bod_run <= '0;
		end else begin
			bod_run <= (stby && BROWNOUT_DETECTOR_EN) ? bod_run + 4'h1 : 4'h0;
		end
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	a_lp_cpu_gated: assert property (LP_ACK |-> !CPU_CLK_EN && !MEM_CLK_EN && POR_DETECT_EN)
		else $error("cpu or memory clock on in low power");
	a_idle_bod_on: assert property (LP_ACK && PERIPH_PWR |-> BROWNOUT_DETECTOR_EN && SRAM_PWR)
		else $error("idle lost detector or sram");
	a_stby_only_aon: assert property (stby |-> !FLASH_PWR && !RADIO_PWR && !FAST_CRYSTAL_OSC_EN && !FAST_DOUBLER_EN)
		else $error("standby left a domain on");
	a_pins_latched: assert property (LP_ACK && !PERIPH_PWR |-> GPIO_LATCH)
		else $error("pins not latched");
	a_hold_stable: assert property ($past(GPIO_LATCH) && GPIO_LATCH |-> $stable(GPIO_HOLD_VAL))
		else $error("held pin level moved");
	a_shdn_all_off: assert property (LP_ACK && !ALWAYS_ON_DOMAIN_PWR |-> !SLOW_RC_OSC_EN && !SLOW_CRYSTAL_OSC_EN && !BROWNOUT_DETECTOR_EN && !SRAM_PWR)
		else $error("shutdown left a source on");
	a_slow_source: assert property (LP_ACK && ALWAYS_ON_DOMAIN_PWR |-> SLOW_RC_OSC_EN != SLOW_XTAL_PRESENT && SLOW_CRYSTAL_OSC_EN == SLOW_XTAL_PRESENT)
		else $error("slow clock source wrong");
	a_bod_duty: assert property (bod_run <= RECHG_ON_CYC)
		else $error("standby detector window too long");
	a_wake_time: assert property ($rose(CPU_CLK_EN) |-> lat >= lim - 2 && lat <= lim + 8)
		else $error("wake latency off");
	a_pin_hold: assert property (!RESET_PIN_N [*6] |-> !SYS_RESET_N && !CPU_CLK_EN)
		else $error("reset pin did not hold system");
	c_idle: cover property (LP_ACK && PERIPH_PWR);
	c_stby: cover property (stby);
	c_shdn: cover property (LP_ACK && !ALWAYS_ON_DOMAIN_PWR);
endmodule // pmc_top_asserts

bind pmc_top pmc_top_asserts u_chk (.*);

// File: bench/pmc_wake_src.sv
// Model of the wake sources: interrupt, clock compare, sensor event, reset pin
// Assumes the bench pulses a request bit for a cycle, or holds it
`timescale 1ns/1ps
module pmc_wake_src (
	input  wire logic       CORE_CLK,
	input  wire logic [3:0] fire,
	output logic            IRQ_EVENT,
	output logic            RTC_EVENT,
	output logic            SENSOR_EVENT,
	output logic            RESET_PIN_N
);
	// ----
	// Event stretch so the synchroniser sees every request
	// ----
	logic [2:0] cnt [4] = '{default: 3'h0};
	logic [3:0] ev;
	always @(posedge CORE_CLK) begin
		for (int i = 0; i < 4; i++) begin
			cnt[i] <= fire[i] ? 3'h6 : ((cnt[i] != 3'h0) ? cnt[i] - 3'h1 : 3'h0);
		end
	end
	for (genvar g = 0; g < 4; g++) begin : g_ev
		assign ev[g] = fire[g] | (cnt[g] != 3'h0);
	end
	assign IRQ_EVENT = ev[0];
	assign RTC_EVENT = ev[1];
	assign SENSOR_EVENT = ev[2];
	assign RESET_PIN_N = !ev[3];
endmodule // pmc_wake_src

// File: bench/tb_top.sv
// Self-checking bench of the power-mode controller
// Assumes pmc_top, the wake source model and the bound checker
`timescale 1ns/1ps
module tb_top;
	import pmc_pkg::*;
	logic CORE_CLK = 0, ARST_N = 0, CLK_EN = 1, POR_EVENT = 0, BROWNOUT_TRIP = 0, SLOW_XTAL_PRESENT = 0;
	logic S_AWVALID = 0, S_WVALID = 0, S_BREADY = 0, S_ARVALID = 0, S_RREADY = 0;
	logic [7:0] S_AWADDR = 0, S_ARADDR = 0;
	logic [31:0] S_WDATA = 0, S_RDATA;
	logic [3:0] S_WSTRB = 4'hF, fire = 0, SRAM_RETAIN;
	logic [1:0] S_BRESP, S_RRESP;
	logic [NGPIO-1:0] WAKE_PIN = 0, GPIO_IN = 0, GPIO_HOLD_VAL;
	logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, IRQ_EVENT, RTC_EVENT, SENSOR_EVENT, RESET_PIN_N;
	logic CPU_CLK_EN, MEM_CLK_EN, FLASH_PWR, SRAM_PWR, CACHE_AS_RAM, RADIO_PWR, PERIPH_PWR, ALWAYS_ON_DOMAIN_PWR;
	logic FAST_CRYSTAL_OSC_EN, FAST_DOUBLER_EN, SLOW_CRYSTAL_OSC_EN, SLOW_RC_OSC_EN, BROWNOUT_DETECTOR_EN;
	logic POR_DETECT_EN, GPIO_LATCH, SYS_RESET_N, LP_ACK, IRQ;
	logic [31:0] mdl [7] = '{32'h0, 32'h0, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0};
	int fail_count = 0;
	int comparisons = 0;
	pmc_top dut (.*);
	pmc_wake_src u_src (.*);
	// ----
	// Clock, shared tasks
	// ----
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge CORE_CLK);
		S_AWADDR <= a;
		S_WDATA <= d;
		S_AWVALID <= 1;
		S_WVALID <= 1;
		S_BREADY <= 1;
		do begin
			@(posedge CORE_CLK);
			n++;
			if (S_AWREADY) S_AWVALID <= 0;
			if (S_WREADY) S_WVALID <= 0;
		end while (!S_BVALID && n < 60);
		S_BREADY <= 0;
		chk("bresp", S_BRESP, (a > OFS_MASK) ? RESP_SLVERR : RESP_OK);
		if (a <= OFS_MASK) mdl[a[4:2]] = d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		int n = 0;
		@(posedge CORE_CLK);
		S_ARADDR <= a;
		S_ARVALID <= 1;
		S_RREADY <= 1;
		do begin
			@(posedge CORE_CLK);
			n++;
			if (S_ARREADY) S_ARVALID <= 0;
		end while (!S_RVALID && n < 60);
		S_RREADY <= 0;
		chk(nm, S_RDATA, e);
		chk("rresp", S_RRESP, (a > OFS_MASK) ? RESP_SLVERR : RESP_OK);
	endtask
	task automatic await(input bit cpu, input logic v, input int lim, output int n);
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while ((cpu ? CPU_CLK_EN : LP_ACK) !== v && n < lim);
		if (n >= lim) fail_count++;
	endtask
	task automatic pulse(input logic [3:0] f);
		@(posedge CORE_CLK);
		fire <= f;
		@(posedge CORE_CLK);
		fire <= 4'h0;
	endtask
	task give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#1400000;
		fail_count++;
		give_verdict;
	end
	// ----
	// Scenarios
	// ----
	initial begin
		logic [31:0] r = 32'h1ada;
		int n;
		repeat (12) @(posedge CORE_CLK);
		ARST_N <= 1;
		await(1, 1, 102000, n);
		chk("por wake", n inside {[WAKE_SHDN_CYC:WAKE_SHDN_CYC + 10]}, 1);
		rd(OFS_RCAUSE, {29'h0, RC_POR}, "rcause");
		rd(OFS_STAT, 32'h1, "stat active");
		rd(OFS_RETN, mdl[2], "retn reset");
		rd(8'h1C, RD_ZERO, "unmapped");
		wr(8'h1C, 32'h1);
		wr(OFS_MASK, 32'hF);
		wr(OFS_CTRL, {30'h0, REQ_IDLE});
		await(0, 1, 60, n);
		chk("idle clocks", {CPU_CLK_EN, MEM_CLK_EN, PERIPH_PWR}, 3'b001);
		rd(OFS_STAT, 32'h4, "stat idle");
		chk("irq raised", IRQ, 1);
		pulse(4'h1);
		await(1, 1, 1500, n);
		chk("idle wake", n inside {[WAKE_IDLE_CYC:WAKE_IDLE_CYC + 10]}, 1);
		rd(OFS_IRQ, 32'h3, "irq status");
		wr(OFS_IRQ, 32'h3);
		rd(OFS_IRQ, 32'h0, "irq cleared");
		chk("irq low", IRQ, 0);
		r = nx(r);
		wr(OFS_MASK, 32'h0);
		wr(OFS_RETN, {28'h0, r[3:0]});
		wr(OFS_CTRL, 32'h10);
		repeat (2) @(posedge CORE_CLK);
		chk("cache ram", CACHE_AS_RAM, 1);
		GPIO_IN <= r[15:8];
		wr(OFS_CTRL, 32'h10 | REQ_STBY);
		await(0, 1, 60, n);
		chk("retain", SRAM_RETAIN, r[3:0]);
		chk("stby pwr", {FLASH_PWR, RADIO_PWR, PERIPH_PWR, FAST_CRYSTAL_OSC_EN, FAST_DOUBLER_EN,
			ALWAYS_ON_DOMAIN_PWR, SLOW_RC_OSC_EN}, 7'h03);
		GPIO_IN <= ~r[15:8];
		pulse(4'h1);
		repeat (60) @(posedge CORE_CLK);
		chk("stby stays", {LP_ACK, GPIO_HOLD_VAL}, {1'b1, r[15:8]});
		pulse(4'h2);
		await(1, 1, 17500, n);
		chk("stby wake", n inside {[WAKE_STBY_CYC:WAKE_STBY_CYC + 10]}, 1);
		rd(OFS_RETN, mdl[2], "retn kept");
		rd(OFS_IRQ, 32'h3, "irq masked status");
		chk("irq masked", IRQ, 0);
		wr(OFS_MASK, 32'h2);
		repeat (2) @(posedge CORE_CLK);
		chk("irq unmasked", IRQ, 1);
		wr(OFS_WPIN, 32'h1);
		r = nx(r);
		GPIO_IN <= r[7:0];
		wr(OFS_CTRL, {30'h0, REQ_SHDN});
		await(0, 1, 60, n);
		mdl[2] = 32'hF;
		chk("shdn pwr", {ALWAYS_ON_DOMAIN_PWR, SLOW_RC_OSC_EN, BROWNOUT_DETECTOR_EN, SRAM_PWR,
			POR_DETECT_EN, GPIO_HOLD_VAL}, {5'h01, r[7:0]});
		rd(OFS_RETN, mdl[2], "retn lost");
		WAKE_PIN <= 8'h2;
		repeat (30) @(posedge CORE_CLK);
		chk("pin off", LP_ACK, 1);
		WAKE_PIN <= 8'h3;
		await(0, 0, 30, n);
		chk("pin wake", LP_ACK, 0);
		fire <= 4'h8;
		repeat (20) @(posedge CORE_CLK);
		chk("pin hold", {SYS_RESET_N, CPU_CLK_EN}, 2'b00);
		give_verdict;
	end
endmodule // tb_top
